// *** shared/utp_pkg.sv ***
// Constants, types and helpers for the UTMI parallel port block.
// Assumes a single 200 MHz clock and active-high asynchronous reset.
package utp_pkg;

  // ************
  // Timing
  // ************
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int MCLK_MHZ = 200;
  localparam int PAR16_MHZ = 30;
  localparam int PAR8_MHZ = 60;
  localparam logic [3:0] DIV16_CYC = 4'(MCLK_MHZ / PAR16_MHZ);
  localparam logic [3:0] DIV8_CYC = 4'(MCLK_MHZ / PAR8_MHZ);
  localparam int HS_BIT_PS = 2083;
  localparam int HS_SYNC_MIN_BITS = 8;
  localparam int HS_SYNC_MAX_BITS = 16;
  localparam logic [3:0] HS_SYNC_CYC = 4'((HS_SYNC_MIN_BITS * HS_BIT_PS
    + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);
  localparam logic [3:0] HS_SYNC_MAX_CYC =
    4'((HS_SYNC_MAX_BITS * HS_BIT_PS) / MCLK_PERIOD_PS);
  localparam logic [1:0] STRAP_CYC = 2'h2;

  // ************
  // Register map
  // ************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_ERRCNT = 8'h08;
  localparam int CTRL_USABLE_BIT = 0;
  localparam logic CTRL_USABLE_RST = 1'b0;
  localparam logic [15:0] ERRCNT_RST = 16'h0000;

  // ************
  // Types
  // ************
  typedef enum logic [1:0] {
    OPM_NORMAL = 2'h0,
    OPM_NODRIVE = 2'h1,
    OPM_RAW = 2'h2,
    OPM_RSVD = 2'h3
  } utp_opmode_e;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_WAIT = 2'h1,
    TX_DATA = 2'h3,
    TX_EOP = 2'h2
  } utp_txst_e;

  typedef struct packed {
    logic syncDet;
    logic eop;
    logic stuffErr;
    logic wordValid;
    logic hiValid;
    logic [15:0] word;
  } utp_rxline_s;

  typedef struct packed {
    logic syncStart;
    logic eopStart;
    logic wordValid;
    logic hiValid;
    logic [15:0] word;
    logic hsSel;
    logic rawMode;
  } utp_txline_s;

  // ************
  // Helpers
  // ************
  function automatic logic [15:0] utp_lanes(logic bw16, logic uni,
                                             logic [15:0] w);
    return bw16 ? w : (uni ? {w[7:0], 8'h00} : {8'h00, w[7:0]});
  endfunction

  function automatic logic [15:0] utp_oe(logic bw16, logic uni,
                                          logic txv);
    logic [15:0] m;
    m = bw16 ? 16'hFFFF : (uni ? 16'hFF00 : 16'h00FF);
    return (txv && !uni) ? 16'h0000 : m;
  endfunction

endpackage

// *** src/utp_sync2.sv ***
// Two-stage synchroniser for pin inputs.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/10ps
module utp_sync2 #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_ff <= '0;
      dout <= '0;
    end
    else
    begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end

endmodule

// *** src/utp_core.sv ***
// UTMI parallel port, transceiver side, with an APB register slave.
// Assumes the SIE runs on mclk; pins and straps are asynchronous.
`timescale 1ns/10ps

// Summary of operation
// - Line state bit0 follows D+, bit1 follows D-
// - Line state follows pins freely until clock usable, then per clock
// - OpMode 00 normal, 01 non-driving, 10 raw; 11 reserved
// - Raising TXValid starts a SYNC on the line
// - Dropping TXValid starts an EOP on the line
// - Full speed: SYNC starts one to two parallel clocks after TXValid
// - High speed: SYNC starts 8 to 16 bit times after TXValid; code starts it 5 mclk cycles after the parallel clock enable that sees TXValid
// - TXValid and TXReady high loads bus into transmit holding register
// - RXValid high when receive holding register holds a word
// - RXActive rises after SYNC detected
// - RXActive falls after stuff error or EOP
// - RXError set on receive error, cleared when the next SYNC is detected
// - 16-bit, TXValid low: ValidH driven, qualifies received high byte
// - 8-bit mode: ValidH ignored, RXValid qualifies low byte
// - Transceiver select 0 high speed, 1 full speed
// - Width select high 16-bit at 30 MHz, low 8-bit at 60 MHz; code divides mclk by 6 and by 3
// - Width select sampled only at end of reset
// - 8-bit split mode: low byte transmit, high byte receive
module utp_core
  import utp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // UTMI control
  input wire logic txValid,
  input wire logic [1:0] opMode,
  input wire logic xcvrSelect,
  output logic txReady,
  output logic rxValid,
  output logic rxActive,
  output logic rxError,
  output logic [1:0] lineState,
  // UTMI data bus and ValidH
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic [15:0] dataOe,
  input wire logic validHIn,
  output logic validHOut,
  output logic validHOe,
  // Strap and line pins
  input wire logic busWidth16,
  input wire logic uniBidi,
  input wire logic dPlus,
  input wire logic dMinus,
  // Serial engine side
  input utp_rxline_s rxLine,
  input wire logic lineTxTake,
  input wire logic lineEopDone,
  output utp_txline_s txLine
);

  // ************
  // Pin synchronisers and straps
  // ************
  logic [3:0] pinSync;
  logic [1:0] strapCnt_ff;
  logic strapDone_ff;
  logic bw16_ff;
  logic uni_ff;

  utp_sync2 #(.W(4)) uSync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .din({uniBidi, busWidth16, dMinus, dPlus}),
    .dout(pinSync)
  );

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strapCnt_ff <= 2'h0;
      strapDone_ff <= 1'b0;
      bw16_ff <= 1'b0;
      uni_ff <= 1'b0;
    end
    else if (!strapDone_ff)
    begin
      strapCnt_ff <= strapCnt_ff + 2'h1;
      if (strapCnt_ff == STRAP_CYC)
      begin
        strapDone_ff <= 1'b1;
        bw16_ff <= pinSync[2];
        uni_ff <= pinSync[3];
      end
    end
  end

  // ************
  // Parallel clock enable
  // ************
  logic [3:0] divCnt_ff;
  logic parEn_ff;
  logic [3:0] divTop;

  assign divTop = bw16_ff ? DIV16_CYC : DIV8_CYC;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      divCnt_ff <= 4'h0;
      parEn_ff <= 1'b0;
    end
    else
    begin
      parEn_ff <= strapDone_ff && (divCnt_ff == divTop - 4'h1);
      if (!strapDone_ff || divCnt_ff == divTop - 4'h1)
        divCnt_ff <= 4'h0;
      else
        divCnt_ff <= divCnt_ff + 4'h1;
    end
  end

  // ************
  // APB registers
  // ************
  logic clkUsable_ff;
  logic [15:0] errCnt_ff;
  logic apbSetup;
  logic apbWrAcc;
  logic [31:0] statWord;
  utp_txst_e txState_ff;

  assign apbSetup = psel && !penable;
  assign apbWrAcc = psel && penable && pready && pwrite;
  assign statWord = {24'h00_0000, uni_ff, bw16_ff, txState_ff,
                     rxError, rxActive, lineState};

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apbSetup;
      pslverr <= apbSetup && paddr != OFS_CTRL && paddr != OFS_STAT
                 && paddr != OFS_ERRCNT;
      if (apbSetup && !pwrite)
        case (paddr)
          OFS_CTRL: prdata <= {31'h0000_0000, clkUsable_ff};
          OFS_STAT: prdata <= statWord;
          OFS_ERRCNT: prdata <= {16'h0000, errCnt_ff};
          default: prdata <= 32'h0000_0000;
        endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      clkUsable_ff <= CTRL_USABLE_RST;
    else if (apbWrAcc && paddr == OFS_CTRL)
      clkUsable_ff <= pwdata[CTRL_USABLE_BIT];
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      errCnt_ff <= ERRCNT_RST;
    else if (rxLine.stuffErr)
      errCnt_ff <= errCnt_ff + 16'h0001;
    else if (apbWrAcc && paddr == OFS_ERRCNT)
      errCnt_ff <= ERRCNT_RST;
  end

  // ************
  // Line state
  // ************
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      lineState <= 2'h0;
    else if (!clkUsable_ff || parEn_ff)
      lineState <= {pinSync[1], pinSync[0]};
  end

  // ************
  // Transmit path
  // ************
  utp_txst_e nxtTxState;
  logic [3:0] waitCnt_ff;
  logic noDrive;
  logic txLoad;
  logic holdFull_ff;

  assign noDrive = opMode == OPM_NODRIVE || opMode == OPM_RSVD;
  assign txLoad = parEn_ff && txValid && txReady;

  always_comb
  begin
    nxtTxState = txState_ff;
    case (txState_ff)
      TX_IDLE:
        if (parEn_ff && txValid && !noDrive)
          nxtTxState = TX_WAIT;
      TX_WAIT:
        if (xcvrSelect ? parEn_ff : waitCnt_ff == HS_SYNC_CYC - 4'h1)
          nxtTxState = TX_DATA;
      TX_DATA:
        if (parEn_ff && !txValid)
          nxtTxState = TX_EOP;
      TX_EOP:
        if (lineEopDone)
          nxtTxState = TX_IDLE;
      default: nxtTxState = TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      txState_ff <= TX_IDLE;
      waitCnt_ff <= 4'h0;
    end
    else
    begin
      txState_ff <= nxtTxState;
      waitCnt_ff <= (txState_ff == TX_WAIT) ? waitCnt_ff + 4'h1 : 4'h0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      holdFull_ff <= 1'b0;
      txReady <= 1'b0;
      txLine <= '0;
    end
    else
    begin
      if (txLoad)
        holdFull_ff <= 1'b1;
      else if (lineTxTake)
        holdFull_ff <= 1'b0;
      txReady <= nxtTxState == TX_DATA && !txLoad
                 && (!holdFull_ff || lineTxTake);
      txLine.syncStart <= txState_ff == TX_WAIT
                          && nxtTxState == TX_DATA;
      txLine.eopStart <= txState_ff == TX_DATA
                         && nxtTxState == TX_EOP;
      txLine.wordValid <= txLoad || (holdFull_ff && !lineTxTake);
      txLine.hsSel <= !xcvrSelect;
      txLine.rawMode <= opMode == OPM_RAW;
      if (txLoad)
      begin
        txLine.word <= bw16_ff ? dataIn : {8'h00, dataIn[7:0]};
        txLine.hiValid <= bw16_ff && validHIn;
      end
    end
  end

  // ************
  // Receive path
  // ************
  logic rxFull_ff;
  logic [15:0] rxHold_ff;
  logic rxHoldHi_ff;
  logic syncPend_ff;
  logic eopPend_ff;
  logic errPend_ff;
  logic rxShow;
  logic rxEndNow;
  logic nxtRxActive;

  assign rxEndNow = errPend_ff || (eopPend_ff && !rxFull_ff);
  assign nxtRxActive = !rxEndNow && (rxActive || syncPend_ff);
  assign rxShow = parEn_ff && rxFull_ff && nxtRxActive;

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      syncPend_ff <= 1'b0;
      eopPend_ff <= 1'b0;
      errPend_ff <= 1'b0;
    end
    else
    begin
      syncPend_ff <= rxLine.syncDet || (syncPend_ff && !parEn_ff);
      errPend_ff <= rxLine.stuffErr || (errPend_ff && !parEn_ff);
      eopPend_ff <= rxLine.eop
                    || (eopPend_ff && !(parEn_ff && rxEndNow));
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxFull_ff <= 1'b0;
      rxHold_ff <= 16'h0000;
      rxHoldHi_ff <= 1'b0;
    end
    else if (rxLine.wordValid)
    begin
      rxFull_ff <= 1'b1;
      rxHold_ff <= rxLine.word;
      rxHoldHi_ff <= rxLine.hiValid;
    end
    else if (parEn_ff)
      rxFull_ff <= 1'b0;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rxActive <= 1'b0;
      rxError <= 1'b0;
      rxValid <= 1'b0;
      dataOut <= 16'h0000;
      validHOut <= 1'b0;
    end
    else if (parEn_ff)
    begin
      rxActive <= nxtRxActive;
      if (errPend_ff)
        rxError <= 1'b1;
      else if (syncPend_ff)
        rxError <= 1'b0;
      rxValid <= rxShow;
      if (rxShow)
      begin
        dataOut <= utp_lanes(bw16_ff, uni_ff, rxHold_ff);
        validHOut <= bw16_ff && rxHoldHi_ff;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dataOe <= 16'h0000;
      validHOe <= 1'b0;
    end
    else
    begin
      dataOe <= utp_oe(bw16_ff, uni_ff, txValid);
      validHOe <= bw16_ff && !txValid;
    end
  end

  // ************
  // Assertions
  // ************
  AST_RXVALID_ACTIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    rxValid |-> rxActive) else $error("RXValid without RXActive");
  AST_RESET_QUIET: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(sys_rst) |-> !rxValid && !rxActive && !rxError && !txReady)
    else $error("Handshake outputs high after reset");
  AST_LINESTATE: assert property (@(posedge mclk) disable iff (sys_rst)
    !clkUsable_ff |=> lineState == $past({pinSync[1], pinSync[0]}))
    else $error("Line state not following pins");
  AST_FS_SYNC: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(txState_ff == TX_WAIT) && xcvrSelect |-> ##[1:12] txLine.syncStart)
    else $error("Full-speed SYNC late");
  AST_HS_SYNC: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(txState_ff == TX_WAIT) && !xcvrSelect
      |-> !txLine.syncStart[*4] ##[0:2] txLine.syncStart)
    else $error("High-speed SYNC outside window");
  AST_EOP: assert property (@(posedge mclk) disable iff (sys_rst)
    txState_ff == TX_DATA && parEn_ff && !txValid |=> txLine.eopStart)
    else $error("No EOP after TXValid fell");
  AST_TXLOAD: assert property (@(posedge mclk) disable iff (sys_rst)
    txValid && txReady && parEn_ff && bw16_ff
      |=> txLine.word == $past(dataIn) && txLine.wordValid)
    else $error("Transmit word not captured");
  AST_RXERR: assert property (@(posedge mclk) disable iff (sys_rst)
    rxLine.stuffErr |-> ##[1:7] (rxError && !rxActive))
    else $error("Stuff error not reported");
  AST_VALIDH_OE: assert property (@(posedge mclk) disable iff (sys_rst)
    validHOe |-> bw16_ff && !$past(txValid))
    else $error("ValidH driven outside 16-bit receive");
  AST_NODRIVE: assert property (@(posedge mclk) disable iff (sys_rst)
    txState_ff == TX_IDLE && opMode == OPM_NODRIVE |=> txState_ff == TX_IDLE)
    else $error("Transmit started while non-driving");

endmodule

// *** dv/utp_sie_model.sv ***
// Serial interface engine model for the UTMI parallel port.
// Assumes one mclk domain; go is held high for a whole packet.
`timescale 1ns/10ps
module utp_sie_model
  import utp_pkg::*;
#(
  parameter int NW = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Command
  input wire logic go,
  input wire logic [15:0] base,
  // UTMI
  input wire logic txReady,
  input wire logic rxValid,
  input wire logic [15:0] dataOut,
  output logic txValid,
  output logic [15:0] dataIn,
  output logic validHIn,
  output logic [15:0] rxWord,
  output logic [3:0] rxCount
);
  // ************
  // Transmit and receive
  // ************
  logic rdyQ;
  logic rxvQ;
  logic [3:0] idx;
  assign validHIn = txValid;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      txValid <= 1'b0;
      dataIn <= 16'h0000;
      idx <= 4'h0;
      rdyQ <= 1'b0;
      rxvQ <= 1'b0;
      rxWord <= 16'h0000;
      rxCount <= 4'h0;
    end
    else
    begin
      rdyQ <= txReady;
      rxvQ <= rxValid;
      if (!go)
      begin
        txValid <= 1'b0;
        idx <= 4'h0;
      end
      else if (idx == 4'h0)
      begin
        txValid <= 1'b1;
        dataIn <= base;
        idx <= 4'h1;
      end
      else if (rdyQ && !txReady && txValid)
      begin
        // Word taken: next one at once, or end
        idx <= idx + 4'h1;
        dataIn <= (idx == 4'(NW)) ? ~dataIn : base + 16'(idx);
        if (idx == 4'(NW))
          txValid <= 1'b0;
      end
      if (rxValid && !rxvQ)
      begin
        rxWord <= dataOut;
        rxCount <= rxCount + 4'h1;
      end
    end
endmodule

// *** dv/utmi_parallel_port_bench.sv ***
// Testbench for the UTMI parallel port core.
// Assumes 16-bit straps first, 8-bit unidirectional after a second reset.
`timescale 1ns/10ps
module utmi_parallel_port_bench
  import utp_pkg::*;
;
  // ************
  // Signals
  // ************
  logic mclk;
  logic sys_rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, txValid, txReady, rxValid, rxActive, rxError;
  logic [1:0] opMode = 2'h0;
  logic xcvrSelect = 1'b1;
  logic [1:0] lineState;
  logic [15:0] dataIn, dataOut, dataOe, rxWord;
  logic validHIn, validHOut, validHOe;
  logic dPlus = 1'b1;
  logic dMinus = 1'b0;
  logic bw16Pin = 1'b1;
  logic uniPin = 1'b0;
  utp_rxline_s rxLine = '0;
  logic lineTxTake = 1'b0;
  logic lineEopDone = 1'b0;
  utp_txline_s txLine;
  logic go = 1'b0;
  logic [15:0] base = 16'h0000;
  logic [3:0] rxCount;
  logic [15:0] got[$];
  int cyc = 0;
  int nSync = 0;
  int nEop = 0;
  int errCount = 0;
  int nCompared = 0;

  utp_core dut (.mclk, .sys_rst, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .txValid, .opMode, .xcvrSelect,
    .txReady, .rxValid, .rxActive, .rxError, .lineState, .dataIn,
    .dataOut, .dataOe, .validHIn, .validHOut, .validHOe,
    .busWidth16(bw16Pin), .uniBidi(uniPin), .dPlus, .dMinus, .rxLine,
    .lineTxTake, .lineEopDone, .txLine);
  utp_sie_model sie (.mclk, .sys_rst, .go, .base, .txReady, .rxValid,
    .dataOut, .txValid, .dataIn, .validHIn, .rxWord, .rxCount);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Serializer side and timeout
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    lineEopDone <= txLine.eopStart;
    nSync <= nSync + int'(txLine.syncStart);
    nEop <= nEop + int'(txLine.eopStart);
    lineTxTake <= txLine.wordValid && !lineTxTake;
    if (txLine.wordValid && !lineTxTake)
      got.push_back(txLine.word);
    if (cyc == 20000)
    begin
      errCount++;
      printVerdict();
    end
  end

  // ************
  // Tasks
  // ************
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    nCompared++;
    if (g !== e)
    begin
      errCount++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdChk(string nm, logic [7:0] a, logic [31:0] e, logic ee);
    logic [31:0] d;
    logic x;
    apb(1'b0, a, 32'h0000_0000, d, x);
    chk(nm, e, d);
    chk("pslverr", ee, x);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] v);
    logic [31:0] d;
    logic x;
    apb(1'b1, a, v, d, x);
  endtask

  task automatic rxp(logic [4:0] f, logic [15:0] w);
    @(posedge mclk);
    rxLine <= {f, w};
    @(posedge mclk);
    rxLine <= '0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic tLine();
    for (int i = 0; i < 4; i++)
    begin
      {dMinus, dPlus} <= 2'(i);
      repeat (12) @(posedge mclk);
      chk("lineState", i, lineState);
    end
    $display("test line done");
  endtask

  task automatic tTx(logic fs, logic [1:0] om, int lo, int hi,
    logic [15:0] m);
    int c;
    int s0;
    int e0;
    c = 0;
    s0 = nSync;
    e0 = nEop;
    got.delete();
    xcvrSelect <= fs;
    opMode <= om;
    base <= 16'h1230 + 16'(fs);
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    while (nSync == s0 && c < 40)
    begin
      @(posedge mclk);
      c++;
    end
    chk("validHOe", 0, validHOe);
    if (om == OPM_NODRIVE)
      chk("syncs", 0, nSync - s0);
    else
    begin
      chk("syncDelay", 1, c >= lo && c <= hi);
      c = 0;
      while (nEop == e0 && c < 300)
      begin
        @(posedge mclk);
        c++;
      end
      chk("eops", 1, nEop - e0);
      chk("nWords", 2, got.size());
      chk("word0", base & m, got[0]);
      chk("word1", (base + 16'h0001) & m, got[1]);
      chk("hsSel", !fs, txLine.hsSel);
      chk("rawMode", om == OPM_RAW, txLine.rawMode);
      chk("hiValid", m[15], txLine.hiValid);
    end
    go <= 1'b0;
    repeat (8) @(posedge mclk);
    $display("test tx done");
  endtask

  task automatic tRx();
    logic [3:0] n0;
    n0 = rxCount;
    rxp(5'b10000, 16'h0000);
    chk("rxActive", 1, rxActive);
    chk("rxError", 0, rxError);
    rxp(5'b00011, 16'hA5C3);
    chk("rxWord", 16'hA5C3, rxWord);
    chk("rxCount", n0 + 4'h1, rxCount);
    chk("validHOut", 1, validHOut);
    chk("validHOe", 1, validHOe);
    chk("dataOe", 16'hFFFF, dataOe);
    rxp(5'b01000, 16'h0000);
    chk("rxActive", 0, rxActive);
    rxp(5'b10000, 16'h0000);
    rxp(5'b00100, 16'h0000);
    chk("rxActive", 0, rxActive);
    chk("rxError", 1, rxError);
    rdChk("stat", OFS_STAT, 32'h0000_004B, 1'b0);
    rdChk("errcnt", OFS_ERRCNT, 1, 0);
    wr(OFS_ERRCNT, 32'h0000_0000);
    rdChk("errcnt", OFS_ERRCNT, 0, 0);
    chk("rxValid", 0, rxValid);
    $display("test rx done");
  endtask

  task automatic tNarrow();
    logic [3:0] n0;
    bw16Pin <= 1'b0;
    uniPin <= 1'b1;
    sys_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("rxValid", 0, rxValid);
    sys_rst <= 1'b0;
    repeat (12) @(posedge mclk);
    bw16Pin <= 1'b1;
    n0 = rxCount;
    rxp(5'b10000, 16'h0000);
    rxp(5'b00011, 16'hA5C3);
    chk("rxWord", 16'hC300, rxWord);
    chk("rxCount", n0 + 4'h1, rxCount);
    chk("validHOut", 0, validHOut);
    chk("validHOe", 0, validHOe);
    chk("dataOe", 16'hFF00, dataOe);
    rxp(5'b01000, 16'h0000);
    chk("rxActive", 0, rxActive);
    tTx(1'b1, OPM_NORMAL, 6, 8, 16'h00FF);
    rdChk("stat", OFS_STAT, 32'h0000_0083, 1'b0);
    $display("test narrow done");
  endtask

  // ************
  // Main sequence
  // ************
  initial
  begin
    repeat (16) @(posedge mclk);
    chk("txReady", 0, txReady);
    chk("rxActive", 0, rxActive);
    sys_rst <= 1'b0;
    repeat (12) @(posedge mclk);
    rdChk("ctrl", OFS_CTRL, 0, 0);
    rdChk("errcnt", OFS_ERRCNT, 0, 0);
    rdChk("unmapped", 8'h0C, 0, 1);
    tLine();
    wr(OFS_CTRL, 32'h0000_0001);
    rdChk("ctrl", OFS_CTRL, 1, 0);
    tLine();
    tTx(1'b1, OPM_NORMAL, 9, 16, 16'hFFFF);
    tTx(1'b0, OPM_RAW, 7, 14, 16'hFFFF);
    tTx(1'b1, OPM_NODRIVE, 0, 0, 16'hFFFF);
    tRx();
    tNarrow();
    printVerdict();
  end
endmodule
